// [rtl/itf_decode.v]
`timescale 1ns/1ns
`default_nettype none
`include "itf_defines.vh"

// ************************************************************
// Polarity correction and option-code decode, OR over terminals.
// ************************************************************
module itf_decode #(
   parameter N_TERM = 5
) (
   input wire [N_TERM-1:0] term_level,
   input wire [N_TERM*`ITF_SEL_W-1:0] func_sel,
   input wire [N_TERM-1:0] polarity,
   output wire [N_TERM-1:0] term_active,
   output wire [31:0] func_on
);
   genvar t;
   genvar f;

   generate
      for (t = 0; t < N_TERM; t = t + 1) begin : g_term
         wire [`ITF_SEL_W-1:0] sel;
         wire pol_low;
         assign sel = func_sel[t*`ITF_SEL_W +: `ITF_SEL_W];
         // A reset terminal always works active high.
         assign pol_low = polarity[t] & (sel != `ITF_OPT_RESET_CODE);
         assign term_active[t] = term_level[t] ^ pol_low;
      end
      for (f = 0; f < 32; f = f + 1) begin : g_func
         wire [N_TERM-1:0] hit;
         for (t = 0; t < N_TERM; t = t + 1) begin : g_hit
            assign hit[t] = term_active[t] &
               (func_sel[t*`ITF_SEL_W +: `ITF_SEL_W] == f);
         end
         assign func_on[f] = |hit;
      end
   endgenerate
endmodule

`default_nettype wire

// [rtl/itf_defines.vh]
`ifndef ITF_DEFINES_VH
`define ITF_DEFINES_VH

// ************************************************************
// Register byte offsets.
// ************************************************************
`define ITF_OFS_FUNC_SEL 8'h00
`define ITF_OFS_POLARITY 8'h04
`define ITF_OFS_CMD_STAT 8'h08
`define ITF_OFS_IRQ_STAT 8'h0c
`define ITF_OFS_IRQ_CLR 8'h10
`define ITF_OFS_IRQ_EN 8'h14
`define ITF_OFS_TERM_LVL 8'h18
`define ITF_OFS_TRIP_INFO 8'h1c

// ************************************************************
// Field layout and reset values.
// ************************************************************
`define ITF_SEL_W 5
`define ITF_FUNC_SEL_RST 25'h1218820
`define ITF_POLARITY_RST 5'h00
`define ITF_POL_ACT_HIGH 1'b0
`define ITF_POL_ACT_LOW 1'b1
`define ITF_IRQ_TRIP 0
`define ITF_IRQ_TRIP_RESET 1
`define ITF_IRQ_RESTART_BLK 2
`define ITF_IRQ_W 3
`define ITF_TRIP_CODE_EXT 8'h0c

// ************************************************************
// Option codes.
// ************************************************************
`define ITF_OPT_FWD 0
`define ITF_OPT_REV 1
`define ITF_OPT_SPD0 2
`define ITF_OPT_SPD1 3
`define ITF_OPT_SPD2 4
`define ITF_OPT_SPD3 5
`define ITF_OPT_JOG 6
`define ITF_OPT_DCB 7
`define ITF_OPT_MOTOR2 8
`define ITF_OPT_RAMP2 9
`define ITF_OPT_COAST 11
`define ITF_OPT_EXT_TRIP 12
`define ITF_OPT_USP 13
`define ITF_OPT_LOCK 15
`define ITF_OPT_ANALOG 16
`define ITF_OPT_RESET 18
`define ITF_OPT_RESET_CODE 5'h12

// ************************************************************
// Timing.
// ************************************************************
`define ITF_SETTLE_CYC 4'h4

// ************************************************************
// Bus answers.
// ************************************************************
`define ITF_RESP_OKAY 2'b00
`define ITF_RESP_SLVERR 2'b10

`endif

// [rtl/itf_sync.v]
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Two flip-flop synchroniser for the terminal pins.
// ************************************************************
module itf_sync #(
   parameter W = 5
) (
   input wire clk_sys,
   input wire rstn,
   input wire [W-1:0] d_async,
   output reg [W-1:0] q_sync
);
   reg [W-1:0] meta;

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta <= {W{1'b0}};
         q_sync <= {W{1'b0}};
      end else begin
         meta <= d_async;
         q_sync <= meta;
      end
   end
endmodule

`default_nettype wire

// [rtl/itf_top.v]
// Functional notes
// - each terminal takes its selected function
// - polarity setting inverts terminal before decode
// - option 00 runs forward while asserted
// - option 01 runs reverse while asserted
// - options 02-05 form four-bit speed index
// - option 06 runs at jog frequency
// - option 07 enables DC braking
// - option 08 selects second motor parameters
// - option 09 selects second ramp values
// - option 11 switches output off, coasting
// - option 12 rising edge latches trip E12
// - option 13 blocks run resume at power-up
// - option 15 locks parameter writes
// - option 18 clears trip, output off, reset
// - polarity 00 active high, 01 active low
// - reset terminal never active low
// - shared option responds to OR of terminals
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "itf_defines.vh"

module itf_top #(
   parameter N_TERM = 5
) (
   input wire clk_sys,
   input wire rstn,
   input wire [N_TERM-1:0] term_pin,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg forward_run,
   output reg reverse_run,
   output reg jog_run,
   output reg [3:0] speed_sel,
   output reg dc_brake_en,
   output reg motor2_select,
   output reg second_ramp_select,
   output reg motor_output_off,
   output reg trip_latched,
   output reg [7:0] trip_code,
   output reg powerup_reset,
   output reg powerup_restart_block,
   output reg param_write_lock,
   output reg analog_source_select,
   output reg irq
);
   // ************************************************************
   // Configuration and status storage.
   // ************************************************************
   reg [N_TERM*`ITF_SEL_W-1:0] func_sel;
   reg [N_TERM-1:0] polarity;
   reg [`ITF_IRQ_W-1:0] irq_stat;
   reg [`ITF_IRQ_W-1:0] irq_en;
   reg [7:0] trip_count;
   reg ext_prev;
   reg [3:0] settle_cnt;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   wire [N_TERM-1:0] term_level;
   wire [N_TERM-1:0] term_active;
   wire [31:0] func_on;
   wire run_req;
   wire trip_rise;
   wire reset_on;
   wire settle_done;
   wire [`ITF_IRQ_W-1:0] irq_event;
   wire [`ITF_IRQ_W-1:0] irq_clr;
   wire wr_go;
   wire [31:0] sel_merged;
   wire [31:0] pol_merged;
   wire [31:0] en_merged;

   function [31:0] merge_strb;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      integer i;
      begin
         merge_strb = old_val;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge_strb[i*8 +: 8] = new_val[i*8 +: 8];
            end
         end
      end
   endfunction

   function addr_known;
      input [7:0] a;
      begin
         addr_known = (a == `ITF_OFS_FUNC_SEL) || (a == `ITF_OFS_POLARITY) ||
            (a == `ITF_OFS_CMD_STAT) || (a == `ITF_OFS_IRQ_STAT) ||
            (a == `ITF_OFS_IRQ_CLR) || (a == `ITF_OFS_IRQ_EN) ||
            (a == `ITF_OFS_TERM_LVL) || (a == `ITF_OFS_TRIP_INFO);
      end
   endfunction

   // ************************************************************
   // Pin synchronisation and decode.
   // ************************************************************
   itf_sync #(
      .W(N_TERM)
   ) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .d_async(term_pin),
      .q_sync(term_level)
   );

   itf_decode #(
      .N_TERM(N_TERM)
   ) u_decode (
      .term_level(term_level),
      .func_sel(func_sel),
      .polarity(polarity),
      .term_active(term_active),
      .func_on(func_on)
   );

   // Only the listed codes are read, so unlisted codes do nothing.
   assign run_req = func_on[`ITF_OPT_FWD] | func_on[`ITF_OPT_REV] |
      func_on[`ITF_OPT_JOG];
   assign trip_rise = func_on[`ITF_OPT_EXT_TRIP] & ~ext_prev;
   assign reset_on = func_on[`ITF_OPT_RESET];
   assign settle_done = (settle_cnt == `ITF_SETTLE_CYC);

   // ************************************************************
   // Drive commands.
   // ************************************************************
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         forward_run <= 1'b0;
         reverse_run <= 1'b0;
         jog_run <= 1'b0;
         speed_sel <= 4'h0;
         dc_brake_en <= 1'b0;
         motor2_select <= 1'b0;
         second_ramp_select <= 1'b0;
         param_write_lock <= 1'b0;
         analog_source_select <= 1'b0;
         motor_output_off <= 1'b1;
         powerup_reset <= 1'b0;
      end else begin
         // Opposing run requests cancel to a stop.
         forward_run <= func_on[`ITF_OPT_FWD] & ~func_on[`ITF_OPT_REV] &
            ~powerup_restart_block;
         reverse_run <= func_on[`ITF_OPT_REV] & ~func_on[`ITF_OPT_FWD] &
            ~powerup_restart_block;
         jog_run <= func_on[`ITF_OPT_JOG] & ~powerup_restart_block;
         speed_sel <= {func_on[`ITF_OPT_SPD3], func_on[`ITF_OPT_SPD2],
            func_on[`ITF_OPT_SPD1], func_on[`ITF_OPT_SPD0]};
         dc_brake_en <= func_on[`ITF_OPT_DCB];
         motor2_select <= func_on[`ITF_OPT_MOTOR2];
         second_ramp_select <= func_on[`ITF_OPT_RAMP2];
         param_write_lock <= func_on[`ITF_OPT_LOCK];
         analog_source_select <= func_on[`ITF_OPT_ANALOG];
         motor_output_off <= func_on[`ITF_OPT_COAST] | reset_on |
            trip_latched | trip_rise;
         powerup_reset <= reset_on;
      end
   end

   // ************************************************************
   // Trip latch and power-up restart protection.
   // ************************************************************
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ext_prev <= 1'b0;
         trip_latched <= 1'b0;
         trip_code <= 8'h00;
         trip_count <= 8'h00;
         settle_cnt <= 4'h0;
         powerup_restart_block <= 1'b0;
      end else begin
         ext_prev <= func_on[`ITF_OPT_EXT_TRIP];
         if (trip_rise) begin
            trip_latched <= 1'b1;
            trip_code <= `ITF_TRIP_CODE_EXT;
            trip_count <= trip_count + 8'h01;
         end else if (reset_on) begin
            trip_latched <= 1'b0;
            trip_code <= 8'h00;
         end
         // The reset terminal restarts the power-up sequence.
         if (reset_on) begin
            settle_cnt <= 4'h0;
         end else if (!settle_done) begin
            settle_cnt <= settle_cnt + 4'h1;
         end
         if (!settle_done && !reset_on &&
             settle_cnt == `ITF_SETTLE_CYC - 4'h1) begin
            powerup_restart_block <= func_on[`ITF_OPT_USP] & run_req;
         end else if (!run_req) begin
            powerup_restart_block <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Interrupt status.
   // ************************************************************
   assign irq_event[`ITF_IRQ_TRIP] = trip_rise;
   assign irq_event[`ITF_IRQ_TRIP_RESET] = reset_on & trip_latched;
   assign irq_event[`ITF_IRQ_RESTART_BLK] = !settle_done && !reset_on &&
      settle_cnt == `ITF_SETTLE_CYC - 4'h1 &&
      func_on[`ITF_OPT_USP] && run_req;
   assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   assign irq_clr = (wr_go && aw_addr == `ITF_OFS_IRQ_CLR && w_strb[0]) ?
      w_data[`ITF_IRQ_W-1:0] : {`ITF_IRQ_W{1'b0}};
   assign sel_merged = merge_strb({7'h00, func_sel}, w_data, w_strb);
   assign pol_merged = merge_strb({27'h0000000, polarity}, w_data, w_strb);
   assign en_merged = merge_strb({29'h00000000, irq_en}, w_data, w_strb);

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_stat <= {`ITF_IRQ_W{1'b0}};
         irq <= 1'b0;
      end else begin
         // A new event wins over a clear in the same cycle.
         irq_stat <= (irq_stat & ~irq_clr) | irq_event;
         irq <= |(((irq_stat & ~irq_clr) | irq_event) & irq_en);
      end
   end

   // ************************************************************
   // Bus write channel.
   // ************************************************************
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ITF_RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         func_sel <= `ITF_FUNC_SEL_RST;
         polarity <= `ITF_POLARITY_RST;
         irq_en <= {`ITF_IRQ_W{1'b0}};
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_known(aw_addr) ? `ITF_RESP_OKAY :
               `ITF_RESP_SLVERR;
            case (aw_addr)
               `ITF_OFS_FUNC_SEL: begin
                  func_sel <= sel_merged[N_TERM*`ITF_SEL_W-1:0];
               end
               `ITF_OFS_POLARITY: begin
                  polarity <= pol_merged[N_TERM-1:0];
               end
               `ITF_OFS_IRQ_EN: begin
                  irq_en <= en_merged[`ITF_IRQ_W-1:0];
               end
               default: begin
                  irq_en <= irq_en;
               end
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Bus read channel.
   // ************************************************************
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ITF_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_known(s_axi_araddr) ? `ITF_RESP_OKAY :
               `ITF_RESP_SLVERR;
            case (s_axi_araddr)
               `ITF_OFS_FUNC_SEL: begin
                  s_axi_rdata <= {7'h00, func_sel};
               end
               `ITF_OFS_POLARITY: begin
                  s_axi_rdata <= {27'h0000000, polarity};
               end
               `ITF_OFS_CMD_STAT: begin
                  s_axi_rdata <= {16'h0000, analog_source_select,
                     param_write_lock, powerup_restart_block, powerup_reset,
                     trip_latched, motor_output_off, second_ramp_select,
                     motor2_select, dc_brake_en, speed_sel, jog_run,
                     reverse_run, forward_run};
               end
               `ITF_OFS_IRQ_STAT: begin
                  s_axi_rdata <= {29'h00000000, irq_stat};
               end
               `ITF_OFS_IRQ_EN: begin
                  s_axi_rdata <= {29'h00000000, irq_en};
               end
               `ITF_OFS_TERM_LVL: begin
                  s_axi_rdata <= {19'h00000, term_active, 3'h0, term_level};
               end
               `ITF_OFS_TRIP_INFO: begin
                  s_axi_rdata <= {16'h0000, trip_count, trip_code};
               end
               default: begin
                  s_axi_rdata <= 32'h00000000;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

`default_nettype wire

// [tb/itf_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Port-level checks on bus answers and drive commands.
// ************************************************************
module itf_checker (
   input wire clk_sys,
   input wire rstn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire forward_run,
   input wire reverse_run,
   input wire jog_run,
   input wire motor_output_off,
   input wire trip_latched,
   input wire [7:0] trip_code,
   input wire powerup_reset,
   input wire powerup_restart_block
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   run_dir_excl_a: assert property (!(forward_run && reverse_run))
      else $error("both run directions active");
   restart_gate_a: assert property (powerup_restart_block &&
      $past(powerup_restart_block) |-> !forward_run && !reverse_run && !jog_run)
      else $error("run command while restart blocked");
   trip_code_val_a: assert property (trip_latched |-> trip_code == 8'h0c)
      else $error("wrong trip code");
   trip_out_off_a: assert property (trip_latched && $past(trip_latched)
      |-> motor_output_off)
      else $error("output on during trip");
   trip_clear_a: assert property ($fell(trip_latched)
      |-> ##[0:2] powerup_reset)
      else $error("trip cleared without reset");
   rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
endmodule
bind itf_top itf_checker chk (.clk_sys(clk_sys), .rstn(rstn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .forward_run(forward_run), .reverse_run(reverse_run),
   .jog_run(jog_run), .motor_output_off(motor_output_off),
   .trip_latched(trip_latched), .trip_code(trip_code),
   .powerup_reset(powerup_reset),
   .powerup_restart_block(powerup_restart_block));
`default_nettype wire

// [tb/itf_contacts.sv]
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Switch contacts, moving out of step with the system clock.
// ************************************************************
module itf_contacts (
   input wire logic clk_sys,
   input wire logic [4:0] want,
   output logic [4:0] term_pin
);
   initial term_pin = 5'h00;
   always @(posedge clk_sys) begin
      term_pin <= #13 want;
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "itf_defines.vh"
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
fails = fails + 1; $display("mismatch at %0t: got %h want %h", $time, g, e); \
end end
// ************************************************************
// Bus tasks, expectations and scenarios.
// ************************************************************
module testbench;
   logic clk_sys = 1'b0, rstn = 1'b0;
   logic [4:0] want = 5'h00, pol, pin;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, seed = 32'hc9fc, rd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [1:0] rr, br;
   logic [24:0] sel;
   wire [4:0] term_pin;
   wire awready, wready, bvalid, arready, rvalid, fwd, rev, jog, dcb, m2;
   wire r2, off, trip, prst, pblk, lock, ana, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] spd;
   wire [7:0] tcode;
   wire [15:0] cmd_ports = {ana, lock, pblk, prst, trip, off, r2, m2, dcb,
      spd, jog, rev, fwd};
   integer fails = 0, n_compared = 0, i, k;
   always #50 clk_sys = ~clk_sys;
   itf_contacts cts (.clk_sys(clk_sys), .want(want), .term_pin(term_pin));
   itf_top dut (.clk_sys(clk_sys), .rstn(rstn), .term_pin(term_pin),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .forward_run(fwd),
      .reverse_run(rev), .jog_run(jog), .speed_sel(spd), .dc_brake_en(dcb),
      .motor2_select(m2), .second_ramp_select(r2), .motor_output_off(off),
      .trip_latched(trip), .trip_code(tcode), .powerup_reset(prst),
      .powerup_restart_block(pblk), .param_write_lock(lock),
      .analog_source_select(ana), .irq(irq));
   function automatic [31:0] xs(input [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction
   // Keeps the edge-sensitive and reset options out of the random mix.
   function automatic [4:0] pick(input [4:0] v);
      pick = (v == 5'd12 || v == 5'd13 || v == 5'd18) ? v + 5'd7 : v;
   endfunction
   function automatic [15:0] exp_cmd(input [24:0] s, input [4:0] p,
      input [4:0] t);
      logic [31:0] on;
      logic [4:0] o;
      integer j;
      begin
         on = 32'h0;
         for (j = 0; j < 5; j = j + 1) begin
            o = s[5*j+:5];
            on[o] = on[o] | t[j] ^ p[j];
         end
         exp_cmd = {on[16], on[15], 3'h0, on[11], on[9], on[8], on[7],
            on[5:2], on[6], on[1] & !on[0], on[0] & !on[1]};
      end
   endfunction
   task automatic cyc(input integer n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic axw(input [7:0] a, input [31:0] d);
      integer n;
      begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         n = 0;
         do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            br = bresp;
            if (n > 1) bready <= 1'b1;
            n = n + 1;
         end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 100);
         bready <= 1'b0;
         @(posedge clk_sys);
         if (n >= 100) fails = fails + 1;
      end
   endtask
   task automatic axr(input [7:0] a);
      integer n;
      begin
         araddr <= a;
         arvalid <= 1'b1;
         n = 0;
         do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
            rd = rdata;
            rr = rresp;
            if (n > 0) rready <= 1'b1;
            n = n + 1;
         end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 100);
         rready <= 1'b0;
         @(posedge clk_sys);
         if (n >= 100) fails = fails + 1;
      end
   endtask
   task automatic report_and_stop;
      if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #3000000;
      fails = fails + 1;
      report_and_stop;
   end
   initial begin
      cyc(20);
      rstn <= 1'b1;
      axr(`ITF_OFS_FUNC_SEL);
      `CHK(rd, 32'h01218820)
      axr(`ITF_OFS_POLARITY);
      `CHK(rd, 32'h0)
      axr(`ITF_OFS_CMD_STAT);
      `CHK(rd, 32'h0)
      axr(8'h20);
      `CHK({rr, rd}, {2'b10, 32'h0})
      axw(8'h20, 32'hffffffff);
      `CHK(br, 2'b10)
      for (i = 0; i < 40; i = i + 1) begin
         for (k = 0; k < 5; k = k + 1) begin
            seed = xs(seed);
            sel[5*k+:5] = pick(seed[4:0]);
         end
         if (i < 2) sel = i ? 25'h20 : {5'd5, 5'd4, 5'd3, 5'd2, 5'd0};
         seed = xs(seed);
         pol = seed[4:0];
         pin = seed[9:5];
         axw(`ITF_OFS_FUNC_SEL, {7'h0, sel});
         axw(`ITF_OFS_POLARITY, {27'h0, pol});
         `CHK(br, 2'b00)
         want <= pin;
         cyc(6);
         `CHK(cmd_ports, exp_cmd(sel, pol, pin))
         axr(`ITF_OFS_TERM_LVL);
         `CHK(rd[12:0], {pin ^ pol, 3'b000, pin})
      end
      want <= 5'h00;
      axw(`ITF_OFS_POLARITY, 32'h0);
      axw(`ITF_OFS_FUNC_SEL, {7'h0, 5'd10, 5'd10, 5'd18, 5'd10, 5'd12});
      axw(`ITF_OFS_IRQ_EN, 32'h7);
      cyc(6);
      want <= 5'h01;
      cyc(6);
      `CHK({trip, tcode, off, irq}, {1'b1, 8'h0c, 1'b1, 1'b1})
      want <= 5'h00;
      cyc(6);
      `CHK(trip, 1'b1)
      axr(`ITF_OFS_TRIP_INFO);
      `CHK(rd[15:0], 16'h010c)
      axw(`ITF_OFS_IRQ_EN, 32'h0);
      cyc(2);
      `CHK(irq, 1'b0)
      axw(`ITF_OFS_IRQ_EN, 32'h7);
      cyc(2);
      `CHK(irq, 1'b1)
      axw(`ITF_OFS_IRQ_CLR, 32'h1);
      cyc(2);
      `CHK(irq, 1'b0)
      axw(`ITF_OFS_POLARITY, 32'h4);
      cyc(6);
      `CHK({trip, prst}, 2'b10)
      want <= 5'h04;
      cyc(6);
      `CHK({trip, prst, off}, 3'b011)
      axr(`ITF_OFS_IRQ_STAT);
      `CHK(rd[2:0], 3'b010)
      want <= 5'h00;
      cyc(8);
      `CHK({trip, prst}, 2'b00)
      axw(`ITF_OFS_IRQ_CLR, 32'h7);
      axw(`ITF_OFS_POLARITY, 32'h0);
      axw(`ITF_OFS_FUNC_SEL, {7'h0, 5'd10, 5'd10, 5'd18, 5'd0, 5'd13});
      want <= 5'h07;
      cyc(6);
      want <= 5'h03;
      cyc(10);
      `CHK({pblk, fwd}, 2'b10)
      axr(`ITF_OFS_IRQ_STAT);
      `CHK(rd[2], 1'b1)
      want <= 5'h01;
      cyc(6);
      `CHK(pblk, 1'b0)
      want <= 5'h03;
      cyc(6);
      `CHK(fwd, 1'b1)
      report_and_stop;
   end
endmodule
`default_nettype wire
